/* bench/link_peer.sv */
/*
 * Far-end link partner: puts NRZI line levels on the receive pair from a bit queue.
 * Assumes the bench queues 5-bit code groups and switches the line energy.
 */
`timescale 1ns/1ps
module link_peer (
	input wire logic clk_i,
	input wire logic en_i,
	output logic [1:0] rx_line_o,
	output logic energy_o,
	output logic squelch_o
);
	logic bits_q[$];
	logic lvl;
	// Quiet line at time zero
	initial begin
		lvl = 1'b0;
		rx_line_o = phy_pkg::LN_ZERO;
		energy_o = 1'b0;
		squelch_o = 1'b0;
	end
	// Bench queues a code group, bit 0 goes out first
	task automatic push5(input logic [4:0] c);
		for (int i = 0; i < 5; i++) begin
			bits_q.push_back(c[i]);
		end
	endtask: push5
	// One bit a clock; idle ones fill gaps so the receiver can hold lock
	always @(negedge clk_i) begin
		energy_o <= en_i;
		squelch_o <= en_i;
		if (!en_i) begin
			rx_line_o <= phy_pkg::LN_ZERO;
		end else begin
			if ((bits_q.size() > 0) ? bits_q.pop_front() : 1'b1) lvl = ~lvl;
			rx_line_o <= lvl ? phy_pkg::LN_POS : phy_pkg::LN_ZERO;
		end
	end
endmodule: link_peer

/* bench/test_fast_ethernet_pcs.sv */
/*
 * Self-checking bench for the PCS block: management frames, negotiation pages,
 * transmit line codes, receive decode, power modes. Assumes the link_peer model.
 */
`timescale 1ns/1ps
module test_fast_ethernet_pcs;
	typedef logic [1:0] sym_q_t[$];
	localparam logic [4:0] PA = 5'h0b;
	localparam logic [phy_pkg::CW-1:0] NLP_P = phy_pkg::CW'(16'h00c8);
	logic clk_i = 0, rst_i = 1, mdc = 0, md_drv = 1, fib = 0, tx_en = 0, peer_en = 0;
	logic sd_pin = 0, flp_v = 0, rec = 0;
	logic [15:0] flp_pg = 16'h0000;
	logic [3:0] txd = 4'h0;
	logic md_o, md_oe, tx_take, rx_dv, rx_er, flp_send, link, spd, fdx, fiber_signal_detect_in, an_done, lowp;
	logic energy, squelch;
	logic [1:0] tx_line, rx_line;
	logic [3:0] rxd;
	logic [15:0] flp_out;
	wire logic md_w = md_oe ? md_o : md_drv;
	int bad_count = 0, total_checks = 0;
	sym_q_t lq;
	logic [3:0] rq[$], nq[$];
	fast_ethernet_pcs #(.NLP_PERIOD_CYC(NLP_P), .LINK_LOSS_CYC(phy_pkg::CW'(16'h01f4)),
		.LOCK_IDLES(6'h14)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(md_w),
		.mdio_o(md_o), .mdio_oe_o(md_oe), .phy_addr_i(PA), .fiber_mode_i(fib), .txd_i(txd),
		.tx_en_i(tx_en), .tx_take_o(tx_take), .tx_line_o(tx_line), .rx_line_i(rx_line),
		.energy_i(energy), .squelch_i(squelch), .fiber_signal_detect_in_i(sd_pin),
		.rxd_o(rxd), .rx_dv_o(rx_dv), .rx_er_o(rx_er), .flp_page_i(flp_pg),
		.flp_page_valid_i(flp_v), .flp_page_o(flp_out), .flp_send_o(flp_send), .link_o(link),
		.speed100_o(spd), .full_duplex_o(fdx), .sig_detect_o(fiber_signal_detect_in), .an_done_o(an_done),
		.low_power_o(lowp));
	link_peer i_peer (.clk_i(clk_i), .en_i(peer_en), .rx_line_o(rx_line), .energy_o(energy),
		.squelch_o(squelch));
	// 100 MHz clock
	initial forever #5 clk_i = ~clk_i;
	// Line and receive capture, sampled away from the active edge
	always @(negedge clk_i) begin
		if (rec) lq.push_back(tx_line);
		if (rx_dv === 1'b1) rq.push_back(rxd);
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask: close_out
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: word %h expected %h", $time, got, exp);
		end
	endtask: check_word
	task automatic check_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: flag %b expected %b", $time, got, exp);
		end
	endtask: check_bit
	task automatic settle(input int n);
		repeat (n) @(negedge clk_i);
	endtask: settle
	// One whole frame; the bench lets go of the wire for read turnaround and data
	task automatic mdio_xfer(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [32:0] hdr;
		hdr = {1'b1, 2'b01, wr ? 2'b01 : 2'b10, pa, ra, wr ? 2'b10 : 2'b11, wd};
		for (int i = 32; i >= 0; i--) begin
			md_drv = (wr || i > 17) ? hdr[i] : 1'b1;
			mdc = 1'b0;
			settle(5);
			if (i < 16) rd[i] = md_w;
			mdc = 1'b1;
			settle(5);
		end
		md_drv = 1'b1;
		mdc = 1'b0;
		settle(10);
	endtask: mdio_xfer
	task automatic rd(input logic [4:0] ra, output logic [15:0] v);
		mdio_xfer(1'b0, PA, ra, 16'h0000, v);
	endtask: rd
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] dummy;
		mdio_xfer(1'b1, PA, ra, d, dummy);
	endtask: wr
	task automatic page(input logic [15:0] p);
		flp_pg = p;
		flp_v = 1'b1;
		@(negedge clk_i);
		flp_v = 1'b0;
		settle(5);
	endtask: page
	task automatic do_reset();
		rst_i = 1'b1;
		settle(10);
		rst_i = 1'b0;
		settle(6);
	endtask: do_reset
	// Back-to-back random nibbles with the line recorded throughout
	task automatic send_nibs(input int n);
		int k;
		nq.delete();
		lq.delete();
		rec = 1'b1;
		tx_en = 1'b1;
		txd = 4'($urandom);
		for (int i = 0; i < n; i++) begin
			for (k = 0; k < 20 && tx_take !== 1'b1; k++) @(negedge clk_i);
			nq.push_back(txd);
			txd = 4'($urandom);
			@(negedge clk_i);
		end
		tx_en = 1'b0;
		settle(12);
		rec = 1'b0;
	endtask: send_nibs
	function automatic logic has_seq(input sym_q_t hay, input sym_q_t pat);
		int m;
		for (int s = 0; s + pat.size() <= hay.size(); s++) begin
			for (m = 0; m < pat.size() && hay[s + m] === pat[m]; m++) ;
			if (m == pat.size()) return 1'b1;
		end
		return 1'b0;
	endfunction: has_seq
	// Expected line forms worked out from the code tables
	function automatic sym_q_t exp_line(input logic [3:0] n[$], input logic ten);
		sym_q_t p;
		foreach (n[i]) begin
			for (int b = 0; b < (ten ? 4 : 5); b++) begin
				if (ten) p.push_back(n[i][b] ? phy_pkg::LN_NEG : phy_pkg::LN_POS);
				if (ten) p.push_back(n[i][b] ? phy_pkg::LN_POS : phy_pkg::LN_NEG);
				else p.push_back({1'b0, phy_pkg::ENC[n[i]][b]});
			end
		end
		return p;
	endfunction: exp_line
	function automatic sym_q_t nrzi(input sym_q_t q);
		sym_q_t p;
		for (int i = 1; i < q.size(); i++) p.push_back({1'b0, q[i] !== q[i - 1]});
		return p;
	endfunction: nrzi
	// Three-level code never jumps straight between the outer levels
	function automatic logic mlt_ok(input sym_q_t q);
		logic seen;
		seen = 1'b0;
		for (int i = 1; i < q.size(); i++) begin
			if ((q[i] ^ q[i - 1]) == 2'b10) return 1'b0;
			if (q[i] != phy_pkg::LN_ZERO) seen = 1'b1;
		end
		return seen;
	endfunction: mlt_ok
	// Hang guard well past the expected run length
	initial begin
		settle(60000);
		bad_count++;
		$display("Error %0t: watchdog expired", $time);
		close_out();
	end
	// Main sequence
	initial begin
		logic [15:0] v, v5, nv;
		int k;
		void'($urandom(3));
		do_reset();
		rd(phy_pkg::REG_CTL, v);
		check_word(v, phy_pkg::CTL_RST);
		check_bit(spd, 1'b1);
		check_bit(flp_send, 1'b1);
		rd(phy_pkg::REG_ADV, v);
		check_word(v, phy_pkg::ADV_RST);
		rd(5'h1f, v);
		check_word(v, 16'h0000);
		rd(phy_pkg::REG_LPA, v5);
		wr(phy_pkg::REG_LPA, ~v5);
		rd(phy_pkg::REG_LPA, v);
		check_word(v, v5);
		mdio_xfer(1'b1, PA ^ 5'h01, phy_pkg::REG_ADV, 16'h0000, v);
		rd(phy_pkg::REG_ADV, v);
		check_word(v, phy_pkg::ADV_RST);
		$display("test registers done");
		check_word(flp_out, phy_pkg::ADV_RST);
		wr(phy_pkg::REG_ADV, 16'h00a1);
		check_word(flp_out, phy_pkg::ADV_RST);
		wr(phy_pkg::REG_CTL, phy_pkg::CTL_RST | 16'h0200);
		check_word(flp_out, 16'h00a1);
		rd(phy_pkg::REG_CTL, v);
		check_word(v, phy_pkg::CTL_RST);
		page(16'h01e1);
		for (k = 0; k < 200 && an_done !== 1'b1; k++) @(negedge clk_i);
		check_bit(an_done, 1'b1);
		check_bit(spd, 1'b1);
		check_bit(fdx, 1'b0);
		rd(phy_pkg::REG_LPA, v);
		check_word(v, 16'h01e1);
		$display("test base page done");
		nv = {1'b0, 15'($urandom)};
		wr(phy_pkg::REG_NPT, nv);
		wr(phy_pkg::REG_PSC, 16'h1000);
		wr(phy_pkg::REG_ADV, 16'h80a1);
		wr(phy_pkg::REG_CTL, phy_pkg::CTL_RST | 16'h0200);
		check_word(flp_out, 16'h80a1);
		page(16'h81e1);
		check_word(flp_out, nv);
		v5 = {1'b0, 15'($urandom)};
		page(v5);
		rd(phy_pkg::REG_LPN, v);
		check_word(v, v5);
		rd(phy_pkg::REG_LPA, v);
		check_word(v, 16'h81e1);
		check_bit(an_done, 1'b1);
		$display("test next page done");
		wr(phy_pkg::REG_CTL, 16'h0000);
		settle(20);
		check_bit(spd, 1'b1);
		wr(phy_pkg::REG_CTL, 16'h0200);
		check_bit(spd, 1'b0);
		check_bit(fdx, 1'b0);
		send_nibs(6);
		check_bit(has_seq(lq, exp_line(nq, 1'b1)), 1'b1);
		$display("test ten transmit done");
		wr(phy_pkg::REG_CTL, 16'h0800);
		check_bit(lowp, 1'b1);
		peer_en = 1'b1;
		tx_en = 1'b1;
		k = 0;
		repeat (100) begin
			@(negedge clk_i);
			if (tx_take !== 1'b0 || tx_line !== phy_pkg::LN_ZERO) k++;
		end
		tx_en = 1'b0;
		check_word(16'(k), 16'h0000);
		check_bit(lowp, 1'b1);
		wr(phy_pkg::REG_CTL, 16'h0000);
		check_bit(lowp, 1'b0);
		check_bit(link, 1'b1);
		$display("test power down done");
		// Restart with negotiation on; the idle partner never sends a page
		wr(phy_pkg::REG_CTL, 16'h3200);
		check_bit(spd, 1'b1);
		check_bit(link, 1'b1);
		check_bit(fdx, 1'b0);
		check_bit(an_done, 1'b1);
		send_nibs(8);
		check_bit(mlt_ok(lq), 1'b1);
		rq.delete();
		nq.delete();
		settle(60);
		i_peer.push5(phy_pkg::J5);
		i_peer.push5(phy_pkg::K5);
		repeat (4) begin
			nq.push_back(4'($urandom));
			i_peer.push5(phy_pkg::ENC[nq[nq.size() - 1]]);
		end
		i_peer.push5(phy_pkg::T5);
		settle(150);
		// Locked on the idles, so every data group of the frame is decoded
		check_word(16'(rq.size()), 16'h0004);
		if (rq.size() == 4) begin
			foreach (nq[i]) check_word({12'h000, rq[i]}, {12'h000, nq[i]});
		end
		$display("test copper done");
		peer_en = 1'b0;
		wr(phy_pkg::REG_PSC, 16'h4000);
		for (k = 0; k < 100 && lowp !== 1'b1; k++) @(negedge clk_i);
		check_bit(lowp, 1'b1);
		check_bit(link, 1'b0);
		for (k = 0; k < 300 && tx_line !== phy_pkg::LN_POS; k++) @(negedge clk_i);
		k = 0;
		do begin
			@(negedge clk_i);
			k++;
		end while (k < 400 && tx_line !== phy_pkg::LN_POS);
		check_word(16'(k), 16'(NLP_P));
		rd(phy_pkg::REG_PSC, v);
		check_word(v, 16'h4000);
		peer_en = 1'b1;
		for (k = 0; k < 50 && lowp !== 1'b0; k++) @(negedge clk_i);
		check_bit(lowp, 1'b0);
		$display("test energy sense done");
		fib = 1'b1;
		sd_pin = 1'b1;
		do_reset();
		check_bit(fiber_signal_detect_in, 1'b1);
		sd_pin = 1'b0;
		settle(6);
		check_bit(fiber_signal_detect_in, 1'b0);
		wr(phy_pkg::REG_PSC, 16'h0040);
		check_bit(fiber_signal_detect_in, 1'b1);
		send_nibs(8);
		check_bit(has_seq(nrzi(lq), exp_line(nq, 1'b0)), 1'b1);
		rq.delete();
		nq.delete();
		i_peer.push5(phy_pkg::J5);
		i_peer.push5(phy_pkg::K5);
		repeat (6) begin
			nq.push_back(4'($urandom));
			i_peer.push5(phy_pkg::ENC[nq[nq.size() - 1]]);
		end
		i_peer.push5(phy_pkg::T5);
		settle(200);
		check_bit(rq.size() >= 6, 1'b1);
		if (rq.size() >= 6) begin
			foreach (nq[i]) check_word({12'h000, rq[rq.size() - 6 + i]}, {12'h000, nq[i]});
		end
		$display("test fiber done");
		close_out();
	end
endmodule: test_fast_ethernet_pcs

/* pkg/phy_pkg.sv */
/*
 * Shared constants for the 10/100 PCS and link-control block: management
 * register map, control field positions, line symbols, code groups, timing.
 * Assumes a 100 MHz system clock and a management frame of 13 header bits.
 */
package phy_pkg;
	// Management register map
	localparam logic [4:0] REG_CTL = 5'h00;
	localparam logic [4:0] REG_ADV = 5'h04;
	localparam logic [4:0] REG_LPA = 5'h05;
	localparam logic [4:0] REG_NPT = 5'h07;
	localparam logic [4:0] REG_LPN = 5'h08;
	localparam logic [4:0] REG_PSC = 5'h10;
	// Field positions
	localparam int C_RST = 15;
	localparam int C_SPD = 13;
	localparam int C_ANEN = 12;
	localparam int C_PD = 11;
	localparam int C_RSTRT = 9;
	localparam int C_DUP = 8;
	localparam int P_ESE = 14;
	localparam int P_NPR = 12;
	localparam int P_POL = 6;
	localparam int NP_BIT = 15;
	localparam int AB_HI = 8;
	localparam int AB_LO = 5;
	// Reset values; self-clearing control bits
	localparam logic [15:0] CTL_RST = 16'h3100;
	localparam logic [15:0] ADV_RST = 16'h01e1;
	localparam logic [15:0] SELF_CLR = 16'h8200;
	// Line symbols
	localparam logic [1:0] LN_ZERO = 2'b00;
	localparam logic [1:0] LN_POS = 2'b01;
	localparam logic [1:0] LN_NEG = 2'b11;
	// Code groups, bit 0 goes on the line first
	localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
		5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	localparam logic [4:0] IDLE5 = 5'h1f;
	localparam logic [4:0] J5 = 5'h18;
	localparam logic [4:0] K5 = 5'h11;
	localparam logic [4:0] T5 = 5'h0d;
	localparam logic [9:0] JK10 = {K5, J5};
	localparam logic [3:0] SFD_TAIL = 4'b1101;
	// Management frame
	localparam logic [1:0] OP_RD = 2'b10;
	localparam logic [3:0] HDR_LAST = 4'd12;
	localparam logic [3:0] DATA_LAST = 4'd15;
	localparam logic [1:0] INIT_CAP = 2'd2;
	localparam logic [1:0] INIT_DONE = 2'd3;
	// Symbol timing, cycles per code group / nibble
	localparam logic [2:0] T100_LAST = 3'd4;
	localparam logic [2:0] T10_LAST = 3'd7;
	localparam logic [2:0] R100_LAST = 3'd4;
	localparam logic [2:0] R10_LAST = 3'd3;
	// Lock and idle supervision, in bits
	localparam logic [5:0] LOCK_IDLES = 6'd40;
	localparam logic [3:0] IDLE_RUN = 4'd10;
	localparam logic [9:0] IDLE_WIN = 10'd1000;
	// Timers
	localparam int CW = 27;
	localparam int CLK_NS = 10;
	localparam int NLP_PERIOD_MS = 1000;
	localparam int LINK_LOSS_MS = 150;
	localparam logic [CW-1:0] NLP_PERIOD_CYC = CW'(NLP_PERIOD_MS * (1_000_000 / CLK_NS));
	localparam logic [CW-1:0] LINK_LOSS_CYC = CW'(LINK_LOSS_MS * (1_000_000 / CLK_NS));
	typedef enum logic [3:0] {MD_IDLE = 4'b0001, MD_HDR = 4'b0010, MD_TA = 4'b0100,
		MD_DAT = 4'b1000} md_t;
	typedef enum logic [3:0] {AN_OFF = 4'b0001, AN_ABIL = 4'b0010, AN_NP = 4'b0100,
		AN_GOOD = 4'b1000} an_t;
endpackage: phy_pkg

/* src/fast_ethernet_pcs.sv */
/*
 * PCS, link monitor, negotiation arbiter, power modes and management slave.
 * Assumes line symbols arrive as 2-bit levels from the analog front end and
 * partner pages arrive already decoded on the system clock.
 */
`timescale 1ns/1ps
module fast_ethernet_pcs #(
	parameter logic [phy_pkg::CW-1:0] NLP_PERIOD_CYC = phy_pkg::NLP_PERIOD_CYC,
	parameter logic [phy_pkg::CW-1:0] LINK_LOSS_CYC = phy_pkg::LINK_LOSS_CYC,
	parameter logic [5:0] LOCK_IDLES = phy_pkg::LOCK_IDLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	input wire logic [4:0] phy_addr_i,
	input wire logic fiber_mode_i,
	input wire logic [3:0] txd_i,
	input wire logic tx_en_i,
	output logic tx_take_o,
	output logic [1:0] tx_line_o,
	input wire logic [1:0] rx_line_i,
	input wire logic energy_i,
	input wire logic squelch_i,
	input wire logic fiber_signal_detect_in_i,
	output logic [3:0] rxd_o,
	output logic rx_dv_o,
	output logic rx_er_o,
	input wire logic [15:0] flp_page_i,
	input wire logic flp_page_valid_i,
	output logic [15:0] flp_page_o,
	output logic flp_send_o,
	output logic link_o,
	output logic speed100_o,
	output logic full_duplex_o,
	output logic sig_detect_o,
	output logic an_done_o,
	output logic low_power_o
);
	typedef struct packed {
		logic mdc1, mdc2, mdc3, mdi1, mdi2, en1, en2, sq1, sq2, sd1, sd2, fb1, fb2;
		logic [1:0] rl1, rl2, rp;
		logic [4:0] pa1, pa2, phyad;
		logic [1:0] init;
		logic fiber;
		phy_pkg::md_t mst;
		logic [3:0] mcnt;
		logic [15:0] msh;
		logic [4:0] mreg;
		logic mrd, mhit, mdo, moe;
		logic [15:0] ctl, adv, lpa, npt, lpn, psc, advl, npl, flp;
		logic spd, dup, fsend, done, sleep, lowp;
		logic [2:0] tcnt;
		logic [4:0] tsh;
		logic [10:0] slf, dlf;
		logic [1:0] mlt, tline, rsv;
		logic take, lock, rfr, rph, rdv, rer, link10, link, sdet;
		logic [5:0] lcnt;
		logic [9:0] iwin, rsh;
		logic [3:0] irun, rxd;
		logic [2:0] rpos;
		logic [phy_pkg::CW-1:0] ntim, stim;
		phy_pkg::an_t ast;
	} st_t;

	st_t q;
	st_t n;
	logic wr, kick, quiet, last, b, x, tr, key, d, ok, fsd, nlp;
	logic [15:0] wd, rdw;
	logic [4:0] dc;

	// Decoder: {valid, nibble}; no match means an invalid code group
	function automatic logic [4:0] dec5b(input logic [4:0] c);
		dec5b = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (phy_pkg::ENC[i] == c) dec5b = {1'b1, 4'(i)};
		end
	endfunction: dec5b

	// Three-level phase to line symbol
	function automatic logic [1:0] mlt_lvl(input logic [1:0] p);
		mlt_lvl = p[0] ? (p[1] ? phy_pkg::LN_NEG : phy_pkg::LN_POS) : phy_pkg::LN_ZERO;
	endfunction: mlt_lvl

	// Highest common ability: {speed100, full duplex}
	function automatic logic [1:0] resolve(input logic [3:0] c);
		resolve = c[3] ? 2'b11 : c[2] ? 2'b10 : c[1] ? 2'b01 : 2'b00;
	endfunction: resolve

	// Whole next state; management, line, detect and strap pins pass two flops before use; transmit and page inputs are used directly
	always_comb begin
		n = q;
		wr = 1'b0;
		kick = 1'b0;
		dc = 5'h00;
		wd = {q.msh[14:0], q.mdi2};
		{n.mdc1, n.mdc2, n.mdc3} = {mdc_i, q.mdc1, q.mdc2};
		{n.mdi1, n.mdi2, n.en1, n.en2} = {mdio_i, q.mdi1, energy_i, q.en1};
		{n.sq1, n.sq2, n.sd1, n.sd2} = {squelch_i, q.sq1, fiber_signal_detect_in_i, q.sd1};
		{n.fb1, n.fb2, n.rl1, n.rl2} = {fiber_mode_i, q.fb1, rx_line_i, q.rl1};
		{n.pa1, n.pa2} = {phy_addr_i, q.pa1};
		n.take = 1'b0;
		n.rdv = 1'b0;
		n.rer = 1'b0;
		quiet = q.ctl[phy_pkg::C_PD] | q.sleep;
		// Straps caught after release; seed the scrambler from the address
		if (q.init != phy_pkg::INIT_DONE) begin
			n.init = q.init + 2'd1;
			if (q.init == phy_pkg::INIT_CAP) begin
				n.phyad = q.pa2;
				n.fiber = q.fb2;
				n.slf = {q.pa2, ~q.pa2, 1'b1};
				kick = 1'b1;
			end
		end
		// Read data mux; unmapped addresses read zero
		case (q.mreg)
			phy_pkg::REG_CTL: rdw = q.ctl;
			phy_pkg::REG_ADV: rdw = q.adv;
			phy_pkg::REG_LPA: rdw = q.lpa;
			phy_pkg::REG_NPT: rdw = q.npt;
			phy_pkg::REG_LPN: rdw = q.lpn;
			phy_pkg::REG_PSC: rdw = q.psc;
			default: rdw = 16'h0000;
		endcase
		// Management slave, sampled on MDC rise; preamble not required
		if (q.mdc2 && !q.mdc3) begin
			unique case (q.mst)
				phy_pkg::MD_IDLE: begin
					if (!q.mdi2) n.mst = phy_pkg::MD_HDR;
					n.mcnt = 4'd0;
				end
				phy_pkg::MD_HDR: begin
					n.msh = wd;
					n.mcnt = q.mcnt + 4'd1;
					if (q.mcnt == 4'd0 && !q.mdi2) begin
						n.mst = phy_pkg::MD_IDLE;
					end else if (q.mcnt == phy_pkg::HDR_LAST) begin
						n.mst = phy_pkg::MD_TA;
						n.mcnt = 4'd0;
						n.mreg = wd[4:0];
						n.mrd = q.msh[10:9] == phy_pkg::OP_RD;
						n.mhit = q.msh[8:4] == q.phyad;
					end
				end
				phy_pkg::MD_TA: begin
					n.mcnt = q.mcnt + 4'd1;
					if (q.mcnt == 4'd1) begin
						n.mst = phy_pkg::MD_DAT;
						n.mcnt = 4'd0;
						n.msh = rdw;
					end
				end
				phy_pkg::MD_DAT: begin
					n.msh = wd;
					n.mcnt = q.mcnt + 4'd1;
					if (q.mcnt == phy_pkg::DATA_LAST) begin
						n.mst = phy_pkg::MD_IDLE;
						wr = !q.mrd && q.mhit;
					end
				end
				default: n.mst = phy_pkg::MD_IDLE;
			endcase
		end
		// Drive on MDC fall so the master samples a settled bit
		if (!q.mdc2 && q.mdc3) begin
			n.moe = q.mrd && q.mhit && ((q.mst == phy_pkg::MD_TA && q.mcnt == 4'd1)
				|| q.mst == phy_pkg::MD_DAT);
			n.mdo = (q.mst == phy_pkg::MD_DAT) && q.msh[15];
		end
		// Register writes; reset and restart bits self-clear
		if (wr) begin
			case (q.mreg)
				phy_pkg::REG_CTL: begin
					n.ctl = wd & ~phy_pkg::SELF_CLR;
					kick = wd[phy_pkg::C_RST] | wd[phy_pkg::C_RSTRT]
						| (q.ctl[phy_pkg::C_PD] & ~wd[phy_pkg::C_PD]);
				end
				phy_pkg::REG_ADV: n.adv = wd;
				phy_pkg::REG_NPT: n.npt = wd;
				phy_pkg::REG_PSC: n.psc = wd;
				default: n.ctl = q.ctl;
			endcase
		end
		// Transmit: one bit per cycle at 100, half bit per cycle at 10
		last = q.spd ? q.tcnt == phy_pkg::T100_LAST : q.tcnt == phy_pkg::T10_LAST;
		n.tcnt = last ? 3'd0 : q.tcnt + 3'd1;
		b = q.spd ? q.tsh[0] : q.tsh[q.tcnt[2:1]];
		x = q.slf[8] ^ q.slf[10];
		// Hold off the shift on the strap edge, or the address seed would be lost
		if (q.init != phy_pkg::INIT_CAP) n.slf = {q.slf[9:0], x};
		if (q.spd) n.tsh = last ? (tx_en_i ? phy_pkg::ENC[txd_i] : phy_pkg::IDLE5) : q.tsh >> 1;
		else if (last) n.tsh = {tx_en_i, txd_i};
		n.take = last && tx_en_i && !quiet;
		if (q.fiber) n.mlt = q.mlt ^ {1'b0, b};
		else n.mlt = q.mlt + {1'b0, b ^ x};
		if (quiet) n.tline = (q.sleep && q.stim == '0) ? phy_pkg::LN_POS : phy_pkg::LN_ZERO;
		else if (!q.spd) n.tline = !q.tsh[4] ? phy_pkg::LN_ZERO
			: ((q.tcnt[0] ? b : ~b) ? phy_pkg::LN_POS : phy_pkg::LN_NEG);
		else if (q.fiber) n.tline = n.mlt[0] ? phy_pkg::LN_POS : phy_pkg::LN_NEG;
		else n.tline = mlt_lvl(n.mlt);
		// Receive: a level change is a one on either line code
		n.rp = q.rl2;
		tr = q.rl2 != q.rp;
		key = q.dlf[8] ^ q.dlf[10];
		d = q.fiber ? tr : tr ^ key;
		fsd = q.sd2 ^ q.psc[phy_pkg::P_POL];
		// Unlocked: assume idle and load the key from the line
		if (!q.lock) begin
			n.dlf = {q.dlf[9:0], ~tr};
			n.lcnt = (key == ~tr) ? q.lcnt + 6'd1 : 6'd0;
			if (q.lcnt == LOCK_IDLES) n.lock = 1'b1;
		end else begin
			n.dlf = {q.dlf[9:0], key};
		end
		n.irun = !d ? 4'd0 : (q.irun == phy_pkg::IDLE_RUN) ? q.irun : q.irun + 4'd1;
		n.iwin = (q.irun == phy_pkg::IDLE_RUN) ? 10'd0 : q.iwin + 10'd1;
		if (q.iwin == phy_pkg::IDLE_WIN || !q.en2 || q.fiber || quiet) begin
			n.lock = 1'b0;
			n.lcnt = 6'd0;
		end
		ok = q.fiber ? fsd : q.lock;
		if (quiet) begin
			n.rfr = 1'b0;
		end else if (q.spd) begin
			// Align on J/K, then strobe a nibble every five bits
			n.rsh = {d, q.rsh[9:1]};
			n.rpos = (q.rpos == phy_pkg::R100_LAST) ? 3'd0 : q.rpos + 3'd1;
			dc = dec5b(n.rsh[9:5]);
			if (!q.rfr) begin
				n.rfr = ok && n.rsh == phy_pkg::JK10;
				n.rpos = 3'd0;
			end else if (q.rpos == phy_pkg::R100_LAST) begin
				n.rxd = dc[3:0];
				n.rdv = dc[4] && ok;
				n.rer = !dc[4] && n.rsh[9:5] != phy_pkg::T5;
				n.rfr = ok && n.rsh[9:5] != phy_pkg::T5;
			end
		end else begin
			// Manchester: the second half carries the bit
			n.rph = ~q.rph;
			if (q.rph) begin
				n.rsh = {q.rl2 == phy_pkg::LN_POS, q.rsh[9:1]};
				n.rpos = (q.rpos == phy_pkg::R10_LAST) ? 3'd0 : q.rpos + 3'd1;
				if (!q.rfr) begin
					n.rfr = n.rsh[9:6] == phy_pkg::SFD_TAIL;
					n.rpos = 3'd0;
				end else if (q.rpos == phy_pkg::R10_LAST) begin
					n.rxd = n.rsh[9:6];
					n.rdv = 1'b1;
				end
			end
			if (q.rl2 == phy_pkg::LN_ZERO && q.rp == phy_pkg::LN_ZERO) n.rfr = 1'b0;
		end
		// Normal link pulses: an isolated positive pulse outside frames
		// Never on fiber; next-state strap so the strap edge cannot start parallel detect
		nlp = !quiet && !n.fiber && !q.rfr
			&& q.rl2 == phy_pkg::LN_POS && q.rp == phy_pkg::LN_ZERO;
		if (nlp) begin
			n.link10 = q.ntim < LINK_LOSS_CYC;
			n.ntim = '0;
		end else if (q.ntim >= LINK_LOSS_CYC || quiet) begin
			n.link10 = 1'b0;
		end else begin
			n.ntim = q.ntim + 1'b1;
		end
		n.link = q.spd ? ok : q.link10;
		n.sdet = q.fiber ? fsd : q.en2 & q.sq2 & q.lock;
		if (q.link && !n.link && !quiet) kick = 1'b1;
		// Negotiation arbiter; frozen while asleep or powered down
		if (!quiet) begin
			unique case (q.ast)
				phy_pkg::AN_OFF: n.ast = q.ast;
				phy_pkg::AN_ABIL: begin
					if (flp_page_valid_i) begin
						n.lpa = flp_page_i;
						n.rsv = resolve(q.advl[phy_pkg::AB_HI:phy_pkg::AB_LO]
							& flp_page_i[phy_pkg::AB_HI:phy_pkg::AB_LO]);
						if (q.advl[phy_pkg::NP_BIT] && flp_page_i[phy_pkg::NP_BIT]) begin
							n.ast = phy_pkg::AN_NP;
							n.npl = q.npt;
							n.flp = q.npt;
						end else begin
							n.ast = phy_pkg::AN_GOOD;
							{n.spd, n.dup} = n.rsv;
						end
					end else if (q.link10 || q.lock) begin
						n.ast = phy_pkg::AN_GOOD;
						n.spd = q.lock;
						n.dup = 1'b0;
					end
				end
				phy_pkg::AN_NP: begin
					if (flp_page_valid_i) begin
						if (q.psc[phy_pkg::P_NPR]) n.lpn = flp_page_i;
						else n.lpa = flp_page_i;
						if (q.npl[phy_pkg::NP_BIT] && flp_page_i[phy_pkg::NP_BIT]) begin
							n.npl = q.npt;
							n.flp = q.npt;
						end else begin
							n.ast = phy_pkg::AN_GOOD;
							{n.spd, n.dup} = q.rsv;
						end
					end
				end
				phy_pkg::AN_GOOD: n.ast = q.ast;
				default: n.ast = phy_pkg::AN_OFF;
			endcase
		end
		// Start events apply the staged control bits and relatch the advert
		if (kick) begin
			n.spd = n.ctl[phy_pkg::C_SPD];
			n.dup = n.ctl[phy_pkg::C_DUP];
			n.ast = n.ctl[phy_pkg::C_ANEN] ? phy_pkg::AN_ABIL : phy_pkg::AN_OFF;
			n.advl = n.adv;
			n.flp = n.adv;
		end
		n.fsend = !quiet && (n.ast == phy_pkg::AN_ABIL || n.ast == phy_pkg::AN_NP);
		n.done = n.ast == phy_pkg::AN_GOOD;
		// Energy sense sleep: beacon period counts down, energy wakes
		n.sleep = q.psc[phy_pkg::P_ESE] && !q.en2 && !n.ctl[phy_pkg::C_PD];
		n.stim = !q.sleep ? '0 : (q.stim == '0) ? NLP_PERIOD_CYC - 1'b1 : q.stim - 1'b1;
		n.lowp = n.ctl[phy_pkg::C_PD] | n.sleep;
	end

	// Single state register; constants only under reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.ctl <= phy_pkg::CTL_RST;
			q.adv <= phy_pkg::ADV_RST;
			q.mst <= phy_pkg::MD_IDLE;
			q.ast <= phy_pkg::AN_OFF;
		end else begin
			q <= n;
		end
	end

	assign {mdio_o, mdio_oe_o, tx_take_o, tx_line_o} = {q.mdo, q.moe, q.take, q.tline};
	assign {rxd_o, rx_dv_o, rx_er_o, flp_page_o, flp_send_o} = {q.rxd, q.rdv, q.rer, q.flp, q.fsend};
	assign {link_o, speed100_o, full_duplex_o, sig_detect_o} = {q.link, q.spd, q.dup, q.sdet};
	assign {an_done_o, low_power_o} = {q.done, q.lowp};

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	pd_no_take_a: assert property (q.ctl[phy_pkg::C_PD] [*2] |-> !tx_take_o)
		else $error("transmit nibble taken in power down");
	pd_hold_a: assert property (q.ctl[phy_pkg::C_PD] && !wr |=> q.ctl[phy_pkg::C_PD])
		else $error("power down left without a write");
	decode_lock_a: assert property (rx_dv_o && q.spd && !q.fiber |-> $past(q.lock))
		else $error("nibble decoded without lock");
	copper_sd_a: assert property (sig_detect_o && !q.fiber |-> $past(q.en2 && q.sq2 && q.lock))
		else $error("copper signal detect unqualified");
	fiber_pol_a: assert property (q.fiber ##1 q.fiber |-> sig_detect_o == $past(fsd))
		else $error("fiber signal detect polarity wrong");
	adv_hold_a: assert property (q.ast == phy_pkg::AN_ABIL && $past(q.ast == phy_pkg::AN_ABIL)
		&& !$past(kick) |-> $stable(q.advl))
		else $error("advertisement changed during ability detect");
	np_latch_a: assert property ($rose(q.ast == phy_pkg::AN_NP) |-> q.npl == $past(q.npt))
		else $error("next page word not latched on entry");
	par_half_a: assert property (q.ast == phy_pkg::AN_ABIL && !flp_page_valid_i && !quiet
		&& (q.link10 || q.lock) && !kick |=> !full_duplex_o && an_done_o)
		else $error("parallel detect did not fix half duplex");
	wake_a: assert property (q.sleep && q.en2 |=> !q.sleep ##1 !low_power_o || q.ctl[phy_pkg::C_PD])
		else $error("energy did not wake the block");
	seed_a: assert property (q.init == phy_pkg::INIT_CAP |=> q.slf == {q.phyad, ~q.phyad, 1'b1})
		else $error("scrambler seed not taken from address");
endmodule: fast_ethernet_pcs
